//--- usart_pkg.sv
// Shared constants and types for the serial transceiver block
package usart_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_CTRL_C = 3'h2;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h3;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h4;
  localparam logic [2:0] ADDR_DATA = 3'h5;

  // ==========================================================
  // Field positions
  localparam int A_RX_AVAIL = 7;
  localparam int A_TX_DONE = 6;
  localparam int A_TX_EMPTY = 5;
  localparam int A_FRAME_ERR = 4;
  localparam int A_OVERRUN = 3;
  localparam int A_PARITY_ERR = 2;
  localparam int A_DOUBLE_SPEED = 1;
  localparam int B_XFER_DIR = 5;
  localparam int B_RX_EN = 4;
  localparam int B_TX_EN = 3;
  localparam int B_CHAR_SIZE2 = 2;
  localparam int B_RX_NINTH = 1;
  localparam int B_TX_NINTH = 0;
  localparam int C_SYNC_SEL = 6;
  localparam int C_PARITY_HI = 5;
  localparam int C_PARITY_LO = 4;
  localparam int C_STOP2 = 3;
  localparam int C_CHAR_HI = 2;
  localparam int C_CHAR_LO = 1;
  localparam int C_POLARITY = 0;
  localparam int BAUD_HI_MSB = 3;

  // ==========================================================
  // Encodings
  localparam logic [2:0] CS_5 = 3'h0;
  localparam logic [2:0] CS_6 = 3'h1;
  localparam logic [2:0] CS_7 = 3'h2;
  localparam logic [2:0] CS_8 = 3'h3;
  localparam logic [2:0] CS_9 = 3'h7;
  localparam logic [3:0] NBITS_5 = 4'h5;
  localparam logic [3:0] NBITS_6 = 4'h6;
  localparam logic [3:0] NBITS_7 = 4'h7;
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;
  localparam int DATA_W = 9;
  localparam int ENTRY_W = 11;

  // ==========================================================
  // Timing and reset values
  localparam logic [3:0] OS_NORMAL_LAST = 4'hf;
  localparam logic [3:0] OS_DOUBLE_LAST = 4'h7;
  localparam logic [3:0] OS_NORMAL_MID = 4'h8;
  localparam logic [3:0] OS_DOUBLE_MID = 4'h4;
  localparam logic [11:0] BAUD_DIV_RESET = 12'h000;
  localparam logic [1:0] RX_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_START = 3'b001,
    FR_DATA = 3'b010,
    FR_PARITY = 3'b011,
    FR_STOP = 3'b100
  } frame_state_e;

endpackage

//--- usart_clkgen.sv
// Baud generator and transfer clock logic
`timescale 1ns/10ps
`default_nettype none
module usart_clkgen (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Configuration
  input wire logic [11:0] i_div,
  input wire logic i_div_lo_wr,
  input wire logic i_sync,
  input wire logic i_master,
  input wire logic i_pol,
  // Transfer clock pin
  input wire logic i_xck,
  output logic o_xck_out,
  output logic o_xck_oe,
  // Timing pulses
  output logic o_os_tick,
  output logic o_chg,
  output logic o_smp
);

  logic [11:0] cnt_q;
  logic xck_s1_q;
  logic xck_s2_q;
  logic xck_prev_q;
  logic rise;
  logic fall;

  // ==========================================================
  // Down-counter, one pulse at each zero without a low divisor write
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_q <= usart_pkg::BAUD_DIV_RESET;
      o_os_tick <= 1'b0;
    end
    else
    begin
      if (i_div_lo_wr || cnt_q == 12'h000)
        cnt_q <= i_div;
      else
        cnt_q <= cnt_q - 12'h001;
      o_os_tick <= (cnt_q == 12'h000) && !i_div_lo_wr;
    end
  end

  // ==========================================================
  // Master clock out, driven only in synchronous master mode
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_xck_out <= 1'b0;
      o_xck_oe <= 1'b0;
    end
    else
    begin
      o_xck_oe <= i_sync && i_master;
      if (i_sync && i_master && o_os_tick)
        o_xck_out <= !o_xck_out;
    end
  end

  // ==========================================================
  // Slave clock sync and edge detect
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_prev_q <= 1'b0;
    end
    else
    begin
      xck_s1_q <= i_xck;
      xck_s2_q <= xck_s1_q;
      xck_prev_q <= xck_s2_q;
    end
  end

  assign rise = xck_s2_q && !xck_prev_q;
  assign fall = !xck_s2_q && xck_prev_q;

  // Change and sample edges by polarity
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_chg <= 1'b0;
      o_smp <= 1'b0;
    end
    else if (!i_sync)
    begin
      o_chg <= 1'b0;
      o_smp <= 1'b0;
    end
    else if (i_master)
    begin
      o_chg <= o_os_tick && (o_xck_out == i_pol);
      o_smp <= o_os_tick && (o_xck_out != i_pol);
    end
    else
    begin
      o_chg <= i_pol ? fall : rise;
      o_smp <= i_pol ? rise : fall;
    end
  end

endmodule
`default_nettype wire

//--- usart_core.sv
// Serial transceiver: registers, transmitter, receiver and frame format
`timescale 1ns/10ps
`default_nettype none
module usart_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial data pins
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  // Transfer clock pin
  input wire logic i_transfer_clock_pin_in,
  output logic o_transfer_clock_pin_out,
  output logic o_transfer_clock_pin_oe
);

  logic double_speed_bit_q;
  logic xfer_clock_direction_q;
  logic rx_en_q;
  logic tx_en_q;
  logic tx_ninth_bit_q;
  logic sync_select_q;
  logic [1:0] parity_mode_field_q;
  logic stop_bits_select_q;
  logic [2:0] char_size_field_q;
  logic sync_clock_polarity_q;
  logic [11:0] baud_divisor_q;
  logic div_lo_wr_q;
  logic wr_a, wr_b, wr_c, wr_lo, wr_hi, wr_data, rd_data;
  logic os_tick, chg, smp;
  logic [3:0] os_last, os_mid, n_bits;
  logic par_en, par_odd;

  // ==========================================================
  // Format helpers
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      usart_pkg::CS_5: data_bits = usart_pkg::NBITS_5;
      usart_pkg::CS_6: data_bits = usart_pkg::NBITS_6;
      usart_pkg::CS_7: data_bits = usart_pkg::NBITS_7;
      usart_pkg::CS_9: data_bits = usart_pkg::NBITS_9;
      default: data_bits = usart_pkg::NBITS_8;
    endcase
  endfunction

  function automatic logic [8:0] data_mask(input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < usart_pkg::DATA_W; i++)
      m[i] = (i < int'(n));
    return m;
  endfunction

  // ==========================================================
  // Address decode
  always_comb
  begin
    wr_a = 1'b0;
    wr_b = 1'b0;
    wr_c = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_data = 1'b0;
    if (i_addr == usart_pkg::ADDR_CTRL_A)
      wr_a = i_wr;
    else if (i_addr == usart_pkg::ADDR_CTRL_B)
      wr_b = i_wr;
    else if (i_addr == usart_pkg::ADDR_CTRL_C)
      wr_c = i_wr;
    else if (i_addr == usart_pkg::ADDR_BAUD_LO)
      wr_lo = i_wr;
    else if (i_addr == usart_pkg::ADDR_BAUD_HI)
      wr_hi = i_wr;
    else if (i_addr == usart_pkg::ADDR_DATA)
      wr_data = i_wr;
  end
  assign rd_data = i_rd && (i_addr == usart_pkg::ADDR_DATA);

  // ==========================================================
  // Control registers
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      double_speed_bit_q <= 1'b0;
      xfer_clock_direction_q <= 1'b0;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      sync_select_q <= 1'b0;
      parity_mode_field_q <= 2'h0;
      stop_bits_select_q <= 1'b0;
      char_size_field_q <= usart_pkg::CS_5;
      sync_clock_polarity_q <= 1'b0;
      baud_divisor_q <= usart_pkg::BAUD_DIV_RESET;
      div_lo_wr_q <= 1'b0;
    end
    else
    begin
      div_lo_wr_q <= wr_lo;
      if (wr_a)
        double_speed_bit_q <= i_wdata[usart_pkg::A_DOUBLE_SPEED];
      if (wr_b)
      begin
        xfer_clock_direction_q <= i_wdata[usart_pkg::B_XFER_DIR];
        rx_en_q <= i_wdata[usart_pkg::B_RX_EN];
        tx_en_q <= i_wdata[usart_pkg::B_TX_EN];
        char_size_field_q[2] <= i_wdata[usart_pkg::B_CHAR_SIZE2];
        tx_ninth_bit_q <= i_wdata[usart_pkg::B_TX_NINTH];
      end
      if (wr_c)
      begin
        sync_select_q <= i_wdata[usart_pkg::C_SYNC_SEL];
        parity_mode_field_q <= i_wdata[usart_pkg::C_PARITY_HI:usart_pkg::C_PARITY_LO];
        stop_bits_select_q <= i_wdata[usart_pkg::C_STOP2];
        char_size_field_q[1:0] <= i_wdata[usart_pkg::C_CHAR_HI:usart_pkg::C_CHAR_LO];
        sync_clock_polarity_q <= i_wdata[usart_pkg::C_POLARITY];
      end
      if (wr_lo)
        baud_divisor_q[7:0] <= i_wdata;
      if (wr_hi)
        baud_divisor_q[11:8] <= i_wdata[usart_pkg::BAUD_HI_MSB:0];
    end
  end

  // Mode decode, one shared format for both directions
  assign os_last = (double_speed_bit_q && !sync_select_q) ? usart_pkg::OS_DOUBLE_LAST
                                                          : usart_pkg::OS_NORMAL_LAST;
  assign os_mid = (double_speed_bit_q && !sync_select_q) ? usart_pkg::OS_DOUBLE_MID
                                                         : usart_pkg::OS_NORMAL_MID;
  assign n_bits = data_bits(char_size_field_q);
  assign par_en = parity_mode_field_q[1];
  assign par_odd = parity_mode_field_q[0];

  usart_clkgen u_clkgen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_div(baud_divisor_q),
    .i_div_lo_wr(div_lo_wr_q),
    .i_sync(sync_select_q),
    .i_master(xfer_clock_direction_q),
    .i_pol(sync_clock_polarity_q),
    .i_xck(i_transfer_clock_pin_in),
    .o_xck_out(o_transfer_clock_pin_out),
    .o_xck_oe(o_transfer_clock_pin_oe),
    .o_os_tick(os_tick),
    .o_chg(chg),
    .o_smp(smp)
  );

  // ==========================================================
  // Transmitter
  usart_pkg::frame_state_e tx_state_q;
  logic [3:0] tx_sub_q, tx_cnt_q;
  logic [8:0] tx_buf_q, tx_shift_q;
  logic tx_full_q, tx_par_q, tx_second_q, tx_done_q;
  logic tx_bit_end, tx_stop_done, tx_load, tx_finish;

  assign tx_bit_end = sync_select_q ? chg : (os_tick && tx_sub_q == os_last);
  assign tx_stop_done = !stop_bits_select_q || tx_second_q;
  assign tx_load = tx_en_q && tx_bit_end && tx_full_q &&
                   (tx_state_q == usart_pkg::FR_IDLE ||
                    (tx_state_q == usart_pkg::FR_STOP && tx_stop_done));
  assign tx_finish = tx_en_q && tx_bit_end && !tx_full_q &&
                     tx_state_q == usart_pkg::FR_STOP && tx_stop_done;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      tx_sub_q <= 4'h0;
    else if (os_tick)
      tx_sub_q <= (tx_sub_q >= os_last) ? 4'h0 : tx_sub_q + 4'h1;
  end

  // Single write buffer, write wins over load
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_buf_q <= '0;
      tx_full_q <= 1'b0;
    end
    else if (wr_data)
    begin
      tx_buf_q <= {tx_ninth_bit_q, i_wdata};
      tx_full_q <= 1'b1;
    end
    else if (tx_load)
      tx_full_q <= 1'b0;
  end

  // Done flag: set by hardware, cleared by writing one
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      tx_done_q <= 1'b0;
    else if (tx_finish)
      tx_done_q <= 1'b1;
    else if (wr_a && i_wdata[usart_pkg::A_TX_DONE])
      tx_done_q <= 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_state_q <= usart_pkg::FR_IDLE;
      tx_shift_q <= '0;
      tx_cnt_q <= 4'h0;
      tx_par_q <= 1'b0;
      tx_second_q <= 1'b0;
      o_serial_out_pin <= 1'b1;
    end
    else if (!tx_en_q)
    begin
      tx_state_q <= usart_pkg::FR_IDLE;
      o_serial_out_pin <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_shift_q <= tx_buf_q;
      tx_par_q <= (^(tx_buf_q & data_mask(n_bits))) ^ par_odd;
      o_serial_out_pin <= 1'b0;
      tx_state_q <= usart_pkg::FR_START;
    end
    else if (tx_bit_end)
    begin
      case (tx_state_q)
        usart_pkg::FR_START:
        begin
          o_serial_out_pin <= tx_shift_q[0];
          tx_shift_q <= tx_shift_q >> 1;
          tx_cnt_q <= 4'h1;
          tx_state_q <= usart_pkg::FR_DATA;
        end
        usart_pkg::FR_DATA:
        begin
          tx_second_q <= 1'b0;
          if (tx_cnt_q == n_bits && par_en)
          begin
            o_serial_out_pin <= tx_par_q;
            tx_state_q <= usart_pkg::FR_PARITY;
          end
          else if (tx_cnt_q == n_bits)
          begin
            o_serial_out_pin <= 1'b1;
            tx_state_q <= usart_pkg::FR_STOP;
          end
          else
          begin
            o_serial_out_pin <= tx_shift_q[0];
            tx_shift_q <= tx_shift_q >> 1;
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        usart_pkg::FR_PARITY:
        begin
          o_serial_out_pin <= 1'b1;
          tx_state_q <= usart_pkg::FR_STOP;
        end
        usart_pkg::FR_STOP:
        begin
          if (!tx_stop_done)
            tx_second_q <= 1'b1;
          else
            tx_state_q <= usart_pkg::FR_IDLE;
          o_serial_out_pin <= 1'b1;
        end
        default:
          o_serial_out_pin <= 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Receiver
  usart_pkg::frame_state_e rx_state_q;
  logic [3:0] rx_sub_q, rx_cnt_q;
  logic [8:0] rx_shift_q;
  logic rx_acc_q, rx_perr_q, rx_ovr_q;
  logic rx_sample, rx_start, rx_push, rx_accept, rx_pop;
  logic [usart_pkg::ENTRY_W-1:0] rx_mem_q [0:1];
  logic rx_wr_ptr_q, rx_rd_ptr_q;
  logic [1:0] rx_count_q;
  logic [usart_pkg::ENTRY_W-1:0] rx_head;

  assign rx_sample = sync_select_q ? smp :
                     (os_tick && rx_sub_q == os_mid && rx_state_q != usart_pkg::FR_IDLE);
  assign rx_start = !sync_select_q && os_tick && rx_state_q == usart_pkg::FR_IDLE &&
                    !i_serial_in_pin;
  assign rx_push = rx_en_q && rx_sample && rx_state_q == usart_pkg::FR_STOP;
  assign rx_pop = rd_data && rx_count_q != 2'h0;
  assign rx_accept = rx_push && (rx_count_q != usart_pkg::RX_DEPTH || rx_pop);
  assign rx_head = rx_mem_q[rx_rd_ptr_q];

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rx_sub_q <= 4'h0;
    else if (os_tick && rx_state_q == usart_pkg::FR_IDLE)
      rx_sub_q <= 4'h1;
    else if (os_tick)
      rx_sub_q <= (rx_sub_q >= os_last) ? 4'h0 : rx_sub_q + 4'h1;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rx_state_q <= usart_pkg::FR_IDLE;
      rx_cnt_q <= 4'h0;
      rx_shift_q <= '0;
      rx_acc_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end
    else if (!rx_en_q)
      rx_state_q <= usart_pkg::FR_IDLE;
    else if (rx_start)
      rx_state_q <= usart_pkg::FR_START;
    else if (rx_sample)
    begin
      case (rx_state_q)
        usart_pkg::FR_IDLE, usart_pkg::FR_START:
        begin
          // Async false start returns to idle
          if (!i_serial_in_pin)
            rx_state_q <= usart_pkg::FR_DATA;
          else
            rx_state_q <= usart_pkg::FR_IDLE;
          rx_cnt_q <= 4'h0;
          rx_shift_q <= '0;
          rx_acc_q <= 1'b0;
          rx_perr_q <= 1'b0;
        end
        usart_pkg::FR_DATA:
        begin
          rx_shift_q[rx_cnt_q] <= i_serial_in_pin;
          rx_acc_q <= rx_acc_q ^ i_serial_in_pin;
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == n_bits - 4'h1)
            rx_state_q <= par_en ? usart_pkg::FR_PARITY : usart_pkg::FR_STOP;
        end
        usart_pkg::FR_PARITY:
        begin
          rx_perr_q <= rx_acc_q ^ i_serial_in_pin ^ par_odd;
          rx_state_q <= usart_pkg::FR_STOP;
        end
        default:
          rx_state_q <= usart_pkg::FR_IDLE;
      endcase
    end
  end

  // Two-level receive buffer, framing error from first stop only
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rx_mem_q[0] <= '0;
      rx_mem_q[1] <= '0;
      rx_wr_ptr_q <= 1'b0;
      rx_rd_ptr_q <= 1'b0;
      rx_count_q <= 2'h0;
    end
    else
    begin
      if (rx_accept)
      begin
        rx_mem_q[rx_wr_ptr_q] <= {rx_perr_q, !i_serial_in_pin, rx_shift_q};
        rx_wr_ptr_q <= !rx_wr_ptr_q;
      end
      if (rx_pop)
        rx_rd_ptr_q <= !rx_rd_ptr_q;
      if (rx_accept && !rx_pop)
        rx_count_q <= rx_count_q + 2'h1;
      else if (rx_pop && !rx_accept)
        rx_count_q <= rx_count_q - 2'h1;
    end
  end

  // Overrun: set wins over clear by data read
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rx_ovr_q <= 1'b0;
    else if (rx_push && !rx_accept)
      rx_ovr_q <= 1'b1;
    else if (rx_pop)
      rx_ovr_q <= 1'b0;
  end

  // ==========================================================
  // Read data, valid the cycle after the strobe only
  logic [7:0] rdata_d;
  always_comb
  begin
    rdata_d = 8'h00;
    if (i_addr == usart_pkg::ADDR_CTRL_A)
    begin
      rdata_d[usart_pkg::A_RX_AVAIL] = rx_count_q != 2'h0;
      rdata_d[usart_pkg::A_TX_DONE] = tx_done_q;
      rdata_d[usart_pkg::A_TX_EMPTY] = !tx_full_q;
      rdata_d[usart_pkg::A_FRAME_ERR] = rx_count_q != 2'h0 && rx_head[usart_pkg::DATA_W];
      rdata_d[usart_pkg::A_OVERRUN] = rx_ovr_q;
      rdata_d[usart_pkg::A_PARITY_ERR] = rx_count_q != 2'h0 && rx_head[usart_pkg::DATA_W+1];
      rdata_d[usart_pkg::A_DOUBLE_SPEED] = double_speed_bit_q;
    end
    else if (i_addr == usart_pkg::ADDR_CTRL_B)
    begin
      rdata_d[usart_pkg::B_XFER_DIR] = xfer_clock_direction_q;
      rdata_d[usart_pkg::B_RX_EN] = rx_en_q;
      rdata_d[usart_pkg::B_TX_EN] = tx_en_q;
      rdata_d[usart_pkg::B_CHAR_SIZE2] = char_size_field_q[2];
      rdata_d[usart_pkg::B_RX_NINTH] = rx_head[8];
      rdata_d[usart_pkg::B_TX_NINTH] = tx_ninth_bit_q;
    end
    else if (i_addr == usart_pkg::ADDR_CTRL_C)
    begin
      rdata_d[usart_pkg::C_SYNC_SEL] = sync_select_q;
      rdata_d[usart_pkg::C_PARITY_HI:usart_pkg::C_PARITY_LO] = parity_mode_field_q;
      rdata_d[usart_pkg::C_STOP2] = stop_bits_select_q;
      rdata_d[usart_pkg::C_CHAR_HI:usart_pkg::C_CHAR_LO] = char_size_field_q[1:0];
      rdata_d[usart_pkg::C_POLARITY] = sync_clock_polarity_q;
    end
    else if (i_addr == usart_pkg::ADDR_BAUD_LO)
      rdata_d = baud_divisor_q[7:0];
    else if (i_addr == usart_pkg::ADDR_BAUD_HI)
      rdata_d = {4'h0, baud_divisor_q[11:8]};
    else if (i_addr == usart_pkg::ADDR_DATA)
      rdata_d = rx_head[7:0];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else
      o_rdata <= i_rd ? rdata_d : 8'h00;
  end

endmodule
`default_nettype wire

//--- usart_core_props.sv
// Port-level checks for the serial transceiver
`timescale 1ns/10ps
`default_nettype none
module usart_core_props (
  // Clock
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Bus
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Pins
  input wire logic i_serial_in_pin,
  input wire logic o_serial_out_pin,
  input wire logic i_transfer_clock_pin_in,
  input wire logic o_transfer_clock_pin_out,
  input wire logic o_transfer_clock_pin_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_low2;
    !o_serial_out_pin [*2];
  endsequence
  sequence s_high2;
    o_serial_out_pin [*2];
  endsequence
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  property p_unmapped;
    $past(i_rd) && $past(i_addr) > 3'h5 |-> o_rdata == 8'h00;
  endproperty
  property p_rst_line;
    $fell(i_sys_rst) |-> o_serial_out_pin;
  endproperty
  property p_rst_oe;
    $fell(i_sys_rst) |-> !o_transfer_clock_pin_oe;
  endproperty
  property p_rst_out;
    $fell(i_sys_rst) |-> o_rdata == 8'h00 && !o_transfer_clock_pin_out;
  endproperty
  property p_xck_hold;
    !o_transfer_clock_pin_oe && !$past(o_transfer_clock_pin_oe)
      |-> $stable(o_transfer_clock_pin_out);
  endproperty
  property p_start_low;
    $fell(o_serial_out_pin) |-> s_low2;
  endproperty
  property p_bit_high;
    $rose(o_serial_out_pin) |-> s_high2;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rst_line: assert property (p_rst_line) else $error("line low after reset");
  a_rst_oe: assert property (p_rst_oe) else $error("clock pin driven after reset");
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  a_xck_hold: assert property (p_xck_hold) else $error("clock moved undriven");
  a_start_low: assert property (p_start_low) else $error("low bit too short");
  a_bit_high: assert property (p_bit_high) else $error("high bit too short");
endmodule
bind usart_core usart_core_props u_usart_core_props (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_serial_in_pin(i_serial_in_pin),
  .o_serial_out_pin(o_serial_out_pin),
  .i_transfer_clock_pin_in(i_transfer_clock_pin_in),
  .o_transfer_clock_pin_out(o_transfer_clock_pin_out),
  .o_transfer_clock_pin_oe(o_transfer_clock_pin_oe)
);
`default_nettype wire

//--- usart_peer.sv
// Remote serial peer: frame sender and line sampler
`timescale 1ns/10ps
`default_nettype none
module usart_peer #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic i_clk,
  // Lines
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;
  task automatic send(input logic [13:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      o_line <= f[i];
      repeat (BIT_CYC) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask
  // Bounded wait for start, then mid-bit samples
  task automatic recv(input int n, output logic [13:0] f, output bit ok);
    int w;
    f = '0;
    w = 0;
    while (i_line !== 1'b0 && w < 2000)
    begin
      @(posedge i_clk);
      w++;
    end
    ok = (w < 2000);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = i_line;
      repeat (BIT_CYC) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- usart_clock_and_frame_format_test.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module usart_clock_and_frame_format_test;
  // ====
  // Signals
  logic i_clk, i_sys_rst, i_wr, i_rd, o_tx, rx_line, xck_out, xck_oe, p, xck_in;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, v;
  logic [8:0] m, d9;
  logic [13:0] f, g;
  logic [14:0] rows [5];
  int error_cnt, checked, n, t;
  bit ok;
  usart_core u_usart_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_in_pin(rx_line), .o_serial_out_pin(o_tx),
    .i_transfer_clock_pin_in(xck_in), .o_transfer_clock_pin_out(xck_out),
    .o_transfer_clock_pin_oe(xck_oe));
  usart_peer #(.BIT_CYC(48)) u_usart_peer (.i_clk(i_clk), .i_line(o_tx), .o_line(rx_line));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ====
  // Bus tasks and frame builder
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic fmt(input logic [14:0] r);
    wr(3'h2, {2'b00, r[11:9], r[13:12], 1'b0});
    wr(3'h1, {3'b000, 2'b11, r[14], 1'b0, r[8]});
  endtask
  function automatic void mk(input logic [14:0] r, output logic [13:0] f,
    output logic [8:0] m, output int n);
    int nb;
    nb = (r[14:12] == 3'h7) ? 9 : int'(r[13:12]) + 5;
    m = 9'((1 << nb) - 1);
    f = {4'h0, r[8:0] & m, 1'b0};
    n = nb + 1;
    if (r[11])
    begin
      f[n] = ^(r[8:0] & m) ^ r[10];
      n++;
    end
    f[n] = 1'b1;
    f[n + 1] = r[9];
    n = n + 1 + int'(r[9]);
  endfunction
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_clk);
    error_cnt++;
    wrap_up();
  end
  // ====
  // Main sequence
  initial
  begin
    {i_sys_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 13'h0};
    {error_cnt, checked} = '0;
    xck_in = 1'b0;
    rows = '{{3'h0, 2'h0, 1'b0, 9'h015}, {3'h1, 2'h3, 1'b1, 9'h02a},
      {3'h2, 2'h2, 1'b0, 9'h04d}, {3'h3, 2'h3, 1'b0, 9'h0a5}, {3'h7, 2'h2, 1'b1, 9'h1c3}};
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK(o_tx, 1'b1)
    rd(3'h2, v);
    `CHK(v, 8'h00)
    rd(3'h7, v);
    `CHK(v, 8'h00)
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h02);
    foreach (rows[i])
    begin
      mk(rows[i], f, m, n);
      fmt(rows[i]);
      fork
        wr(3'h5, rows[i][7:0]);
        u_usart_peer.recv(n, g, ok);
      join
      `CHK({ok, g}, {1'b1, f})
      u_usart_peer.send(f, n);
      rd(3'h0, v);
      `CHK(v[7], 1'b1)
      `CHK(v[4:2], 3'h0)
      rd(3'h1, v);
      d9[8] = v[1];
      rd(3'h5, v);
      d9[7:0] = v;
      `CHK(d9 & m, rows[i][8:0] & m)
    end
    fmt({3'h3, 2'h2, 1'b1, 9'h03c});
    mk({3'h3, 2'h2, 1'b1, 9'h03c}, f, m, n);
    f[10] = 1'b0;
    u_usart_peer.send(f, n);
    rd(3'h0, v);
    `CHK(v[4:2], 3'h4)
    rd(3'h5, v);
    f[10] = 1'b1;
    f[9] = ~f[9];
    f[11] = 1'b0;
    u_usart_peer.send(f, n);
    rd(3'h0, v);
    `CHK(v[4:2], 3'h1)
    rd(3'h5, v);
    `CHK(v, 8'h3c)
    wr(3'h2, 8'h40);
    wr(3'h1, 8'h20);
    repeat (3) @(posedge i_clk);
    #1;
    `CHK(xck_oe, 1'b1)
    t = 0;
    repeat (60)
    begin
      p = xck_out;
      @(posedge i_clk);
      #1;
      t += int'(xck_out != p);
    end
    `CHK(t >= 19 && t <= 21, 1'b1)
    // Sync transmit: master then slave, both polarities
    for (int q = 0; q < 4; q++)
    begin
      wr(3'h2, {7'h23, q[0]});
      wr(3'h1, {2'b00, !q[1], 5'h08});
      wr(3'h5, 8'h5a);
      t = 0;
      p = o_tx;
      for (int c = 0; c < 200; c++)
      begin
        @(posedge i_clk);
        if (q[1] && c % 5 == 0)
          xck_in <= !xck_in;
        #1;
        if (o_tx !== p)
        begin
          t++;
          `CHK(q[1] ? xck_in : xck_out, !q[0])
        end
        p = o_tx;
      end
      `CHK(t, 8)
      `CHK(xck_oe, !q[1])
    end
    // Sync master receive, one bit per clock period
    wr(3'h3, 8'h17);
    wr(3'h1, 8'h30);
    mk({3'h3, 2'h0, 1'b0, 9'h0c6}, f, m, n);
    u_usart_peer.send(f, n);
    rd(3'h5, v);
    `CHK(v, 8'hc6)
    wr(3'h2, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(xck_oe, 1'b0)
    // Double speed: eight ticks per bit
    wr(3'h0, 8'h02);
    wr(3'h3, 8'h05);
    mk(rows[3], f, m, n);
    fmt(rows[3]);
    fork
      wr(3'h5, rows[3][7:0]);
      u_usart_peer.recv(n, g, ok);
    join
    `CHK({ok, g}, {1'b1, f})
    u_usart_peer.send(f, n);
    rd(3'h5, v);
    `CHK(v, rows[3][7:0])
    wrap_up();
  end
endmodule
`default_nettype wire
